// file: bench/ecc_checker.sv
// Checker: port-level properties of the emergency call controller
`default_nettype none
module ecc_checker #(
    parameter longint FAST_HALF_CYC = 5,
    parameter longint SLOW_HALF_CYC = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched inputs
    input wire logic cmd_valid_i,
    input wire logic sw_on_i,
    input wire logic alarm_fuse_bad_i,
    input wire logic alarm_cable_bad_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    // Watched outputs
    input wire logic horn_out_positive_o,
    input wire logic horn_out_ground_o,
    input wire logic alarm_out_o,
    input wire logic [ecc_pkg::CMD_W-1:0] work_cmd_o,
    input wire logic alarm_lamp_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    int hi_run;
    ////////////////////////////////
    // Length of the running horn-on phase; cadence is judged when it ends
    always_ff @(posedge clk_i) begin
        if (rst_i || !horn_out_positive_o) begin
            hi_run <= 0;
        end else begin
            hi_run <= hi_run + 1;
        end
    end
    // Bus answers: one-cycle ack, fixed latency, unmapped reads give zero
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    // Call outputs; the sw_on guard skips phases cut short by a reset gesture
    chk_horn_pair: assert property (horn_out_positive_o == horn_out_ground_o)
        else $error("horn drive pair differs");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !alarm_out_o
        && !horn_out_positive_o && work_cmd_o == 16'h0)
        else $error("outputs active after reset");
    chk_alarm_blocks: assert property (alarm_out_o |-> work_cmd_o == 16'h0)
        else $error("working command during alarm");
    chk_cmd_valid: assert property (work_cmd_o != 16'h0 |-> $past(cmd_valid_i, 3))
        else $error("working command without received command");
    chk_fast_cadence: assert property ($fell(horn_out_positive_o) && !alarm_out_o
        && !sw_on_i |-> hi_run == FAST_HALF_CYC)
        else $error("pre-warning horn phase length wrong");
    chk_slow_cadence: assert property ($fell(horn_out_positive_o) && alarm_out_o
        && $past(alarm_out_o) && !sw_on_i |-> hi_run == SLOW_HALF_CYC)
        else $error("alarm horn phase length wrong");
    // Fault lamp extremes: both faults steady, no fault dark
    chk_lamp_steady: assert property ((alarm_fuse_bad_i && alarm_cable_bad_i)[*4]
        |=> alarm_lamp_o)
        else $error("lamp not steady with both faults");
    chk_lamp_dark: assert property ((!alarm_fuse_bad_i && !alarm_cable_bad_i)[*4]
        |=> !alarm_lamp_o)
        else $error("lamp lit without fault");
    cover property ($rose(alarm_out_o));
    cover property ($rose(horn_out_positive_o) && !alarm_out_o);
    cover property (wb_ack_o && !wb_we_i);
endmodule
bind ecc_top ecc_checker #(
    .FAST_HALF_CYC(FAST_HALF_CYC),
    .SLOW_HALF_CYC(SLOW_HALF_CYC)
) chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i),
    .sw_on_i(sw_on_i),
    .alarm_fuse_bad_i(alarm_fuse_bad_i),
    .alarm_cable_bad_i(alarm_cable_bad_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .horn_out_positive_o(horn_out_positive_o),
    .horn_out_ground_o(horn_out_ground_o),
    .alarm_out_o(alarm_out_o),
    .work_cmd_o(work_cmd_o),
    .alarm_lamp_o(alarm_lamp_o),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// file: bench/ecc_tx_model.sv
// Transmitter model: drives decoded operator commands into the receiver
`default_nettype none
module ecc_tx_model (
    // Clock
    input wire logic clk_i,
    // Decoded command pins
    output logic cmd_valid_o,
    output logic [ecc_pkg::CMD_W-1:0] cmd_bits_o,
    output logic sw_emergency_o,
    output logic sw_on_o,
    output logic pull_left_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet at power-up; idle bits never repeat the last word
    initial begin
        cmd_valid_o = 1'b0;
        cmd_bits_o = 16'hFFFF;
        sw_emergency_o = 1'b0;
        sw_on_o = 1'b0;
        pull_left_o = 1'b0;
    end
    // One word held for n cycles, then the bits show its inverse
    task automatic send(input logic [ecc_pkg::CMD_W-1:0] bits, input int n);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_bits_o <= bits;
        repeat (n) @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_bits_o <= ~bits;
    endtask
    // Switch in emergency position for n cycles; short holds must not count
    task automatic emerg(input int n);
        @(posedge clk_i);
        sw_emergency_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        sw_emergency_o <= 1'b0;
    endtask
    // On held, pull-left pressed briefly in the middle
    task automatic gesture();
        @(posedge clk_i);
        sw_on_o <= 1'b1;
        cmd_valid_o <= 1'b1;
        cmd_bits_o <= 16'h0;
        repeat (4) @(posedge clk_i);
        pull_left_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        pull_left_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        sw_on_o <= 1'b0;
        cmd_valid_o <= 1'b0;
        cmd_bits_o <= 16'hFFFF;
    endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Testbench: call sequences, monitoring faults and register access
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint PRE = 200;
    localparam longint INACT = 500;
    localparam int LAMP = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] sel = 4'hF;
    logic a_fuse = 1'b0, a_cable = 1'b0, h_fuse = 1'b0, h_cable = 1'b0;
    logic valid, emerg, sw_on, pull, horn_p, horn_g, alarm, a_lamp, h_lamp, ack, irq;
    logic [ecc_pkg::CMD_W-1:0] bits, work;
    logic [31:0] wb_dat, rd;
    int mismatches = 0;
    int check_count = 0;
    always #4 clk_i = ~clk_i;
    ////////////////////////////////
    // Counts shortened so the whole run stays a few thousand cycles
    ecc_top #(.HOLD_CYC(10), .PREWARN_CYC(PRE), .FAST_HALF_CYC(5), .SLOW_HALF_CYC(10),
        .LAMP_PERIOD_CYC(LAMP), .FLASH_ON_CYC(2), .INACT_CYC(INACT)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(valid), .cmd_bits_i(bits),
        .sw_emergency_i(emerg), .sw_on_i(sw_on), .pull_left_i(pull),
        .alarm_fuse_bad_i(a_fuse), .alarm_cable_bad_i(a_cable),
        .horn_fuse_bad_i(h_fuse), .horn_cable_bad_i(h_cable),
        .horn_out_positive_o(horn_p), .horn_out_ground_o(horn_g), .alarm_out_o(alarm),
        .work_cmd_o(work), .alarm_lamp_o(a_lamp), .horn_lamp_o(h_lamp),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat), .wb_ack_o(ack),
        .irq_o(irq));
    ecc_tx_model tx (.clk_i(clk_i), .cmd_valid_o(valid), .cmd_bits_o(bits),
        .sw_emergency_o(emerg), .sw_on_o(sw_on), .pull_left_o(pull));
    ////////////////////////////////
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Classic cycle; waits for ack, data taken at that edge; the watchdog ends a hang
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = wb_dat;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // High cycles of the alarm lamp or the horn over one lamp period
    task automatic count(input bit lamp, output int k);
        k = 0;
        repeat (LAMP) begin
            @(posedge clk_i);
            k += ((lamp ? a_lamp : horn_p) === 1'b1);
        end
    endtask
    task automatic cmd_try(input logic [15:0] b, input logic [15:0] exp);
        fork
            tx.send(b, 20);
            begin
                w(8);
                check("work_cmd", 32'(exp), 32'(work));
            end
        join
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        w(16);
        rst_i <= 1'b0;
        w(1);
    endtask
    task automatic stop_test();
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the few thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        stop_test();
    end
    initial begin
        int k;
        do_reset();
        check("alarm", 32'h0, 32'(alarm));
        wb(1'b0, ecc_pkg::IRQ_MASK_OFS, 32'h0);
        check("mask", 32'(ecc_pkg::IRQ_MASK_RST), rd);
        wb(1'b1, ecc_pkg::IRQ_MASK_OFS, 32'h1);
        wb(1'b0, ecc_pkg::IRQ_MASK_OFS, 32'h0);
        check("mask", 32'h1, rd);
        // A write without the low byte lane must leave the mask alone
        sel = 4'hE;
        wb(1'b1, ecc_pkg::IRQ_MASK_OFS, 32'h0);
        sel = 4'hF;
        wb(1'b0, ecc_pkg::IRQ_MASK_OFS, 32'h0);
        check("mask_sel", 32'h1, rd);
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'h0, rd);
        wb(1'b1, ecc_pkg::CTRL_OFS, 32'h1);
        cmd_try(16'h00A5, 16'h0);
        wb(1'b1, ecc_pkg::CTRL_OFS, 32'h0);
        cmd_try(16'h00A5, 16'h00A5);
        w(400);
        cmd_try(16'h005A, 16'h005A);
        w(400);
        count(1'b0, k);
        check("horn_idle", 32'h0, 32'(k));
        tx.emerg(5);
        w(10);
        count(1'b0, k);
        check("horn_short", 32'h0, 32'(k));
        fork
            tx.send(16'h0F0F, 60);
            begin
                w(8);
                tx.emerg(20);
                w(5);
                check("work_cmd", 32'h0, 32'(work));
            end
        join
        count(1'b0, k);
        check("horn_fast", 32'(LAMP / 2), 32'(k));
        check("alarm", 32'h0, 32'(alarm));
        check("irq", 32'h1, 32'(irq));
        wb(1'b1, ecc_pkg::IRQ_STAT_OFS, 32'hF);
        w(3);
        check("irq", 32'h0, 32'(irq));
        cmd_try(16'h0003, 16'h0);
        w(int'(PRE));
        check("alarm", 32'h1, 32'(alarm));
        tx.gesture();
        w(5);
        check("alarm", 32'h0, 32'(alarm));
        count(1'b0, k);
        check("horn_off", 32'h0, 32'(k));
        w(440);
        count(1'b0, k);
        check("horn_early", 32'h0, 32'(k));
        w(30);
        count(1'b0, k);
        check("horn_passive", 32'(LAMP / 2), 32'(k));
        tx.gesture();
        w(5);
        count(1'b0, k);
        check("horn_reset", 32'h0, 32'(k));
        w(int'(INACT + PRE + 60));
        check("alarm", 32'h1, 32'(alarm));
        tx.gesture();
        w(5);
        check("alarm_kept", 32'h1, 32'(alarm));
        do_reset();
        check("alarm", 32'h0, 32'(alarm));
        a_fuse <= 1'b1;
        a_cable <= 1'b1;
        h_fuse <= 1'b1;
        h_cable <= 1'b1;
        w(10);
        check("horn_lamp", 32'h1, 32'(h_lamp));
        cmd_try(16'h0005, 16'h0);
        tx.gesture();
        cmd_try(16'h0005, 16'h0005);
        do_reset();
        cmd_try(16'h0005, 16'h0);
        a_cable <= 1'b0;
        w(10);
        count(1'b1, k);
        check("lamp_fuse", 32'h2, 32'(k));
        a_fuse <= 1'b0;
        a_cable <= 1'b1;
        w(10);
        count(1'b1, k);
        check("lamp_cable", 32'(LAMP / 2), 32'(k));
        stop_test();
    end
endmodule
`default_nettype wire

// file: verilog/ecc_pkg.sv
// Package: constants and types for the emergency call controller
`default_nettype none
package ecc_pkg;
    // Clock rate
    localparam longint CLK_HZ = 125000000;
    // Times in their own units
    localparam longint HOLD_MS = 1000;
    localparam longint PREWARN_S = 20;
    localparam longint FAST_HALF_MS = 500;
    localparam longint SLOW_HALF_MS = 1000;
    localparam longint LAMP_PERIOD_MS = 1000;
    localparam longint FLASH_ON_MS = 100;
    // Derived cycle counts
    localparam longint HOLD_CYC = HOLD_MS * CLK_HZ / 1000;
    localparam longint PREWARN_CYC = PREWARN_S * CLK_HZ;
    localparam longint FAST_HALF_CYC = FAST_HALF_MS * CLK_HZ / 1000;
    localparam longint SLOW_HALF_CYC = SLOW_HALF_MS * CLK_HZ / 1000;
    localparam longint LAMP_PERIOD_CYC = LAMP_PERIOD_MS * CLK_HZ / 1000;
    localparam longint FLASH_ON_CYC = FLASH_ON_MS * CLK_HZ / 1000;
    // Working command width
    localparam int CMD_W = 16;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] CMD_OFS = 8'h10;
    // Interrupt status bit positions
    localparam int IRQ_CALL_BIT = 0;
    localparam int IRQ_ALARM_BIT = 1;
    localparam int IRQ_FAULT_BIT = 2;
    localparam int IRQ_RESET_BIT = 3;
    localparam int IRQ_W = 4;
    // Reset values
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic CTRL_RST = 1'b0;
    // Variant codes
    typedef enum logic [1:0] {ECC_STOP_ONLY, ECC_MANUAL, ECC_MANUAL_INACT} ecc_variant_t;
    // Lamp pattern codes
    localparam logic [1:0] LAMP_OK = 2'h0;
    localparam logic [1:0] LAMP_FUSE = 2'h1;
    localparam logic [1:0] LAMP_CABLE = 2'h2;
    localparam logic [1:0] LAMP_BOTH = 2'h3;
endpackage
`default_nettype wire

// file: verilog/ecc_top.sv
// Emergency call controller: call sequencing, monitoring and Wishbone registers
//
// Added by the designer: the Wishbone slave port and the register addresses.
`default_nettype none
module ecc_top #(
    parameter ecc_pkg::ecc_variant_t VARIANT = ecc_pkg::ECC_MANUAL_INACT,
    parameter logic HORN_ONLY = 1'b0,
    parameter int TIMEOUT_MIN = 5,
    parameter longint HOLD_CYC = ecc_pkg::HOLD_CYC,
    parameter longint PREWARN_CYC = ecc_pkg::PREWARN_CYC,
    parameter longint FAST_HALF_CYC = ecc_pkg::FAST_HALF_CYC,
    parameter longint SLOW_HALF_CYC = ecc_pkg::SLOW_HALF_CYC,
    parameter longint LAMP_PERIOD_CYC = ecc_pkg::LAMP_PERIOD_CYC,
    parameter longint FLASH_ON_CYC = ecc_pkg::FLASH_ON_CYC,
    parameter longint INACT_CYC = longint'(TIMEOUT_MIN) * 60 * ecc_pkg::CLK_HZ
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Decoded transmitter commands
    input wire logic cmd_valid_i,
    input wire logic [ecc_pkg::CMD_W-1:0] cmd_bits_i,
    input wire logic sw_emergency_i,
    input wire logic sw_on_i,
    input wire logic pull_left_i,
    // Output monitoring sense pins
    input wire logic alarm_fuse_bad_i,
    input wire logic alarm_cable_bad_i,
    input wire logic horn_fuse_bad_i,
    input wire logic horn_cable_bad_i,
    // Outputs to the machine
    output logic horn_out_positive_o,
    output logic horn_out_ground_o,
    output logic alarm_out_o,
    output logic [ecc_pkg::CMD_W-1:0] work_cmd_o,
    // Fault lamps
    output logic alarm_lamp_o,
    output logic horn_lamp_o,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq_o
);
    typedef enum logic [1:0] {ECC_IDLE, ECC_PREWARN, ECC_ALARM} ecc_state_t;

    localparam int CW = 40;
    localparam logic [CW-1:0] HOLD_N = CW'(HOLD_CYC);
    localparam logic [CW-1:0] PREWARN_N = CW'(PREWARN_CYC);
    localparam logic [CW-1:0] FAST_N = CW'(FAST_HALF_CYC);
    localparam logic [CW-1:0] SLOW_N = CW'(SLOW_HALF_CYC);
    localparam logic [CW-1:0] LAMP_N = CW'(LAMP_PERIOD_CYC);
    localparam logic [CW-1:0] FLASH_N = CW'(FLASH_ON_CYC);
    localparam logic [CW-1:0] INACT_N = CW'(INACT_CYC);
    // Stop-only variant disables every call and all monitoring
    localparam logic CALLS_ON = (VARIANT != ecc_pkg::ECC_STOP_ONLY);
    localparam logic INACT_ON = (VARIANT == ecc_pkg::ECC_MANUAL_INACT);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: pins come from outside the clock domain
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [ecc_pkg::CMD_W-1:0] cmd1_reg;
    logic [ecc_pkg::CMD_W-1:0] cmd2_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            cmd1_reg <= '0;
            cmd2_reg <= '0;
        end else begin
            sync1_reg <= {cmd_valid_i, sw_emergency_i, sw_on_i, pull_left_i,
                          alarm_fuse_bad_i, alarm_cable_bad_i, horn_fuse_bad_i,
                          horn_cable_bad_i};
            sync2_reg <= sync1_reg;
            cmd1_reg <= cmd_bits_i;
            cmd2_reg <= cmd1_reg;
        end
    end
    logic cmd_valid;
    logic sw_emerg;
    logic sw_on;
    logic pull_left;
    logic a_fuse;
    logic a_cable;
    logic h_fuse;
    logic h_cable;
    assign cmd_valid = sync2_reg[7];
    assign sw_emerg = sync2_reg[6];
    assign sw_on = sync2_reg[5];
    assign pull_left = sync2_reg[4];
    assign a_fuse = sync2_reg[3] & CALLS_ON;
    assign a_cable = sync2_reg[2] & CALLS_ON;
    assign h_fuse = sync2_reg[1] & CALLS_ON;
    assign h_cable = sync2_reg[0] & CALLS_ON;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset gesture: rising edge of pull-left while the power switch is held on
    logic pl_prev_reg;
    logic gesture;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pl_prev_reg <= 1'b0;
        end else begin
            pl_prev_reg <= pull_left;
        end
    end
    assign gesture = sw_on & pull_left & ~pl_prev_reg;

    // Manual call: emergency switch held continuously for the hold time
    logic [CW-1:0] hold_cnt_reg;
    logic manual_req;
    always_ff @(posedge clk_i) begin
        if (rst_i || !sw_emerg) begin
            hold_cnt_reg <= '0;
        end else if (hold_cnt_reg < HOLD_N) begin
            hold_cnt_reg <= hold_cnt_reg + CW'(1);
        end
    end
    assign manual_req = CALLS_ON && sw_emerg && (hold_cnt_reg == HOLD_N - CW'(1));

    // Inactivity counter, cleared by every command and by power-up
    logic [CW-1:0] inact_cnt_reg;
    logic inact_req;
    logic [1:0] state_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_valid) begin
            inact_cnt_reg <= '0;
        end else if (state_reg == 2'(ECC_IDLE) && inact_cnt_reg < INACT_N) begin
            inact_cnt_reg <= inact_cnt_reg + CW'(1);
        end else if (state_reg != 2'(ECC_IDLE)) begin
            inact_cnt_reg <= '0;
        end
    end
    assign inact_req = INACT_ON && !cmd_valid && (inact_cnt_reg == INACT_N - CW'(1));

    ////////////////////////////////////////////////////////////////////////////////
    // Call sequencer
    logic passive_reg;
    logic [CW-1:0] phase_cnt_reg;
    logic reset_ok;
    assign reset_ok = gesture && (!passive_reg || state_reg == 2'(ECC_PREWARN));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= 2'(ECC_IDLE);
            passive_reg <= 1'b0;
            phase_cnt_reg <= '0;
        end else begin
            case (ecc_state_t'(state_reg))
                ECC_IDLE: begin
                    phase_cnt_reg <= '0;
                    if (manual_req || inact_req) begin
                        state_reg <= 2'(ECC_PREWARN);
                        passive_reg <= inact_req && !manual_req;
                    end
                end
                ECC_PREWARN: begin
                    if (reset_ok) begin
                        state_reg <= 2'(ECC_IDLE);
                    end else if (phase_cnt_reg == PREWARN_N - CW'(1)) begin
                        state_reg <= 2'(ECC_ALARM);
                        phase_cnt_reg <= '0;
                    end else begin
                        phase_cnt_reg <= phase_cnt_reg + CW'(1);
                    end
                end
                ECC_ALARM: begin
                    // Inactivity calls stay latched until power is removed
                    if (reset_ok) begin
                        state_reg <= 2'(ECC_IDLE);
                    end
                end
                default: state_reg <= 2'(ECC_IDLE);
            endcase
        end
    end

    // Horn rhythm: fast toggle in pre-warning, slow once the alarm is on
    logic [CW-1:0] horn_cnt_reg;
    logic horn_reg;
    logic [CW-1:0] half_n;
    assign half_n = (state_reg == 2'(ECC_ALARM)) ? SLOW_N : FAST_N;
    always_ff @(posedge clk_i) begin
        if (rst_i || state_reg == 2'(ECC_IDLE)) begin
            horn_cnt_reg <= '0;
            horn_reg <= 1'b0;
        end else if (horn_cnt_reg >= half_n - CW'(1)) begin
            horn_cnt_reg <= '0;
            horn_reg <= ~horn_reg;
        end else begin
            horn_cnt_reg <= horn_cnt_reg + CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault block: set when a fault is seen while pull-left was released, so a restart re-imposes it
    logic any_fault;
    logic block_reg;
    assign any_fault = a_fuse | a_cable | h_fuse | h_cable;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            block_reg <= 1'b0;
        end else if (any_fault && !block_reg && !pl_prev_reg) begin
            block_reg <= 1'b1;
        end else if (gesture && state_reg == 2'(ECC_IDLE)) begin
            block_reg <= 1'b0;
        end
    end
    // Once released the block stays off until the next restart
    logic released_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            released_reg <= 1'b0;
        end else if (block_reg && gesture && state_reg == 2'(ECC_IDLE)) begin
            released_reg <= 1'b1;
        end
    end
    logic blocked;
    assign blocked = (block_reg && !released_reg) || (any_fault && !released_reg);

    // Outputs from flip-flops
    logic sw_ctrl_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            horn_out_positive_o <= 1'b0;
            horn_out_ground_o <= 1'b0;
            alarm_out_o <= 1'b0;
            work_cmd_o <= '0;
        end else begin
            horn_out_positive_o <= CALLS_ON & horn_reg;
            horn_out_ground_o <= CALLS_ON & horn_reg;
            alarm_out_o <= CALLS_ON & !HORN_ONLY & (state_reg == 2'(ECC_ALARM));
            if (state_reg != 2'(ECC_IDLE) || manual_req || inact_req || blocked
                || sw_ctrl_reg || !cmd_valid) begin
                work_cmd_o <= '0;
            end else begin
                work_cmd_o <= cmd2_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lamp patterns: short flash for fuse, half-period blink for cable, steady for both
    logic [CW-1:0] lamp_cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || lamp_cnt_reg == LAMP_N - CW'(1)) begin
            lamp_cnt_reg <= '0;
        end else begin
            lamp_cnt_reg <= lamp_cnt_reg + CW'(1);
        end
    end
    function automatic logic lamp_f(input logic fuse, input logic cable,
                                    input logic [CW-1:0] cnt);
        logic r;
        r = 1'b0;
        if (fuse && cable) begin
            r = 1'b1;
        end else if (fuse) begin
            r = (cnt < FLASH_N);
        end else if (cable) begin
            r = (cnt < (LAMP_N >> 1));
        end
        return r;
    endfunction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_lamp_o <= 1'b0;
            horn_lamp_o <= 1'b0;
        end else begin
            alarm_lamp_o <= lamp_f(a_fuse, a_cable, lamp_cnt_reg);
            horn_lamp_o <= lamp_f(h_fuse, h_cable, lamp_cnt_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over a write-one clear
    logic [ecc_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [ecc_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [ecc_pkg::IRQ_W-1:0] irq_set;
    logic [ecc_pkg::IRQ_W-1:0] irq_clr;
    logic fault_prev_reg;
    logic [1:0] state_prev_reg;
    logic wb_req;
    logic wr_stb;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_prev_reg <= 1'b0;
            state_prev_reg <= 2'(ECC_IDLE);
        end else begin
            fault_prev_reg <= any_fault;
            state_prev_reg <= state_reg;
        end
    end
    always_comb begin
        irq_set = '0;
        irq_set[ecc_pkg::IRQ_CALL_BIT] = state_reg == 2'(ECC_PREWARN)
                                         && state_prev_reg == 2'(ECC_IDLE);
        irq_set[ecc_pkg::IRQ_ALARM_BIT] = state_reg == 2'(ECC_ALARM)
                                          && state_prev_reg == 2'(ECC_PREWARN);
        irq_set[ecc_pkg::IRQ_FAULT_BIT] = any_fault && !fault_prev_reg;
        irq_set[ecc_pkg::IRQ_RESET_BIT] = state_reg == 2'(ECC_IDLE)
                                          && state_prev_reg != 2'(ECC_IDLE);
    end
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = wb_req && wb_we_i && wb_sel_i[0];
    assign irq_clr = (wr_stb && wb_adr_i == ecc_pkg::IRQ_STAT_OFS)
                     ? wb_dat_i[ecc_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_reg <= ecc_pkg::IRQ_MASK_RST;
        end else if (wr_stb && wb_adr_i == ecc_pkg::IRQ_MASK_OFS) begin
            irq_mask_reg <= wb_dat_i[ecc_pkg::IRQ_W-1:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Control: software command inhibit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_ctrl_reg <= ecc_pkg::CTRL_RST;
        end else if (wr_stb && wb_adr_i == ecc_pkg::CTRL_OFS) begin
            sw_ctrl_reg <= wb_dat_i[0];
        end
    end

    // Wishbone read and acknowledge, one wait cycle; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i == ecc_pkg::CTRL_OFS) begin
                    wb_dat_o <= {31'h0, sw_ctrl_reg};
                end else if (wb_adr_i == ecc_pkg::STAT_OFS) begin
                    wb_dat_o <= {24'h0, any_fault, blocked, passive_reg, alarm_out_o,
                                 horn_reg, state_reg, 1'b0};
                end else if (wb_adr_i == ecc_pkg::IRQ_STAT_OFS) begin
                    wb_dat_o <= {28'h0, irq_stat_reg};
                end else if (wb_adr_i == ecc_pkg::IRQ_MASK_OFS) begin
                    wb_dat_o <= {28'h0, irq_mask_reg};
                end else if (wb_adr_i == ecc_pkg::CMD_OFS) begin
                    wb_dat_o <= {16'h0, work_cmd_o};
                end
            end
        end
    end
endmodule
`default_nettype wire
